/* verilog/omms_pkg.sv */
// Shared constants and types for the optical module management block.
// Assumes a 20 MHz mclk and an AXI4-Lite master on the same clock.
package omms_pkg;
  // Serial device addresses (7-bit form)
  localparam logic [6:0] OMMS_DEV_ID   = 7'h50;
  localparam logic [6:0] OMMS_DEV_DIAG = 7'h51;
  // Diagnostic map layout
  localparam logic [7:0] OMMS_WP_BASE    = 8'h80;
  localparam logic [7:0] OMMS_MON_BASE   = 8'h60;
  localparam logic [7:0] OMMS_MON_LEN    = 8'h0a;
  localparam logic [7:0] OMMS_ALARM_BASE = 8'h70;
  localparam logic [7:0] OMMS_WARN_BASE  = 8'h74;
  localparam int         OMMS_NPARAM     = 5;
  localparam int         OMMS_THR_STRIDE = 8;
  // Timing
  localparam int OMMS_CLK_NS        = 50;
  localparam int OMMS_TXDIS_MAX_US  = 10;
  localparam int OMMS_TXDIS_MAX_CYC = (OMMS_TXDIS_MAX_US * 1000) / OMMS_CLK_NS;
  localparam int OMMS_TXDIS_CW      = $clog2(OMMS_TXDIS_MAX_CYC + 1);
  // AXI4-Lite register offsets
  localparam logic [7:0] OMMS_REG_CTRL     = 8'h00;
  localparam logic [7:0] OMMS_REG_STATUS   = 8'h04;
  localparam logic [7:0] OMMS_REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] OMMS_REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OMMS_REG_LOS_LVL  = 8'h10;
  localparam logic [7:0] OMMS_REG_MAP_ACC  = 8'h14;
  localparam logic [7:0] OMMS_REG_MAP_DATA = 8'h18;
  localparam logic [7:0] OMMS_REG_FLAGS    = 8'h1c;
  // Reset values
  localparam logic [0:0]  OMMS_CTRL_RST    = 1'h0;
  localparam logic [15:0] OMMS_LOS_LVL_RST = 16'h0000;
  localparam logic [4:0]  OMMS_IRQ_MASK_RST = 5'h00;
  // Interrupt bit positions
  localparam int OMMS_IRQ_TXF   = 0;
  localparam int OMMS_IRQ_LOS   = 1;
  localparam int OMMS_IRQ_ALARM = 2;
  localparam int OMMS_IRQ_WARN  = 3;
  localparam int OMMS_IRQ_SWR   = 4;
  localparam int OMMS_IRQ_N     = 5;
  localparam logic [1:0] OMMS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] OMMS_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] txpwr;
    logic [15:0] rxpwr;
  } omms_mon_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'b0000_0001,
    S_DEVA = 8'b0000_0010,
    S_DACK = 8'b0000_0100,
    S_WORD = 8'b0000_1000,
    S_WACK = 8'b0001_0000,
    S_WRD  = 8'b0010_0000,
    S_RD   = 8'b0100_0000,
    S_RACK = 8'b1000_0000
  } omms_state_t;
endpackage : omms_pkg

/* verilog/omms_top.sv */
// Management and status logic of a pluggable optical module.
// Assumes monitor readings arrive on mclk; serial pins and the transmit
// disable pin are asynchronous and are synchronised here.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module omms_top
  import omms_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        tx_disable,
  input  wire omms_mon_t   mon_in,
  output logic             laser_enable,
  output logic             tx_fault,
  output logic             rx_no_light_flag,
  output logic             module_present_n,
  output logic             irq
);

  logic [7:0] id_mem   [256];
  logic [7:0] diag_mem [256];

  // Pin synchronisers
  logic scl_meta_q, scl_s_q, scl_p_q;
  logic sda_meta_q, sda_s_q, sda_p_q;
  logic txd_meta_q, txd_s_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_meta_q <= 1'b1;
      scl_s_q    <= 1'b1;
      scl_p_q    <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_s_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      txd_meta_q <= 1'b1;
      txd_s_q    <= 1'b1;
    end else begin
      scl_meta_q <= scl_i;
      scl_s_q    <= scl_meta_q;
      scl_p_q    <= scl_s_q;
      sda_meta_q <= sda_i;
      sda_s_q    <= sda_meta_q;
      sda_p_q    <= sda_s_q;
      txd_meta_q <= tx_disable;
      txd_s_q    <= txd_meta_q;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Monitor and flag state
  logic [4:0][15:0] mon_q, mon_d;
  logic [4:0] ahi_q, alo_q, whi_q, wlo_q;
  logic [4:0] ahi_d, alo_d, whi_d, wlo_d;

  function automatic logic [15:0] thr(input int p, input int k);
    thr = {diag_mem[p * OMMS_THR_STRIDE + 2 * k],
           diag_mem[p * OMMS_THR_STRIDE + 2 * k + 1]};
  endfunction : thr

  // Byte as seen by a reader: live values overlay the diagnostic store
  function automatic logic [7:0] map_rd(input logic sel, input logic [7:0] a);
    logic [7:0] off;
    off = a - OMMS_MON_BASE;
    if (!sel) begin
      map_rd = id_mem[a];
    end else if (a >= OMMS_MON_BASE && off < OMMS_MON_LEN) begin
      map_rd = off[0] ? mon_q[off[3:1]][7:0] : mon_q[off[3:1]][15:8];
    end else if (a == OMMS_ALARM_BASE) begin
      map_rd = {ahi_q[0], alo_q[0], ahi_q[1], alo_q[1],
                ahi_q[2], alo_q[2], ahi_q[3], alo_q[3]};
    end else if (a == OMMS_ALARM_BASE + 8'h01) begin
      map_rd = {ahi_q[4], alo_q[4], 6'h00};
    end else if (a == OMMS_WARN_BASE) begin
      map_rd = {whi_q[0], wlo_q[0], whi_q[1], wlo_q[1],
                whi_q[2], wlo_q[2], whi_q[3], wlo_q[3]};
    end else if (a == OMMS_WARN_BASE + 8'h01) begin
      map_rd = {whi_q[4], wlo_q[4], 6'h00};
    end else begin
      map_rd = diag_mem[a];
    end
  endfunction : map_rd

  always_comb begin
    mon_d = {mon_in.rxpwr, mon_in.txpwr, mon_in.bias, mon_in.vcc,
             mon_in.temp};
    for (int p = 0; p < OMMS_NPARAM; p++) begin
      ahi_d[p] = mon_q[p] > thr(p, 0);
      alo_d[p] = mon_q[p] < thr(p, 1);
      whi_d[p] = mon_q[p] > thr(p, 2);
      wlo_d[p] = mon_q[p] < thr(p, 3);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mon_q <= '0;
      ahi_q <= '0;
      alo_q <= '0;
      whi_q <= '0;
      wlo_q <= '0;
    end else begin
      mon_q <= mon_d;
      ahi_q <= ahi_d;
      alo_q <= alo_d;
      whi_q <= whi_d;
      wlo_q <= wlo_d;
    end
  end

  // Serial slave
  omms_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, tx_q, tx_d;
  logic       sel_q, sel_d, rw_q, rw_d, ack_q, ack_d, nack_q, nack_d;
  logic       oe_q, oe_d, ser_we;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    tx_d   = tx_q;
    sel_d  = sel_q;
    rw_d   = rw_q;
    ack_d  = ack_q;
    nack_d = nack_q;
    ser_we = 1'b0;
    if (stop_c) begin
      st_d  = S_IDLE;
      ack_d = 1'b0;
    end else if (start_c) begin
      st_d  = S_DEVA;
      cnt_d = 4'h0;
      ack_d = 1'b0;
    end else begin
      case (st_q)
        S_DEVA, S_WORD, S_WRD: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            ack_d = 1'b1;
            if (st_q == S_DEVA) begin
              if (sh_q[7:1] == OMMS_DEV_ID || sh_q[7:1] == OMMS_DEV_DIAG) begin
                sel_d = (sh_q[7:1] == OMMS_DEV_DIAG);
                rw_d  = sh_q[0];
                st_d  = S_DACK;
              end else begin
                ack_d = 1'b0;
                st_d  = S_IDLE;
              end
            end else if (st_q == S_WORD) begin
              ptr_d = sh_q;
              st_d  = S_WACK;
            end else begin
              ser_we = sel_q && (ptr_q >= OMMS_WP_BASE);
              ptr_d  = ptr_q + 8'h01;
              st_d   = S_WACK;
            end
          end
        end
        S_DACK: begin
          if (scl_fall) begin
            ack_d = 1'b0;
            if (rw_q) begin
              tx_d  = map_rd(sel_q, ptr_q);
              ptr_d = ptr_q + 8'h01;
              st_d  = S_RD;
            end else begin
              st_d = S_WORD;
            end
          end
        end
        S_WACK: begin
          if (scl_fall) begin
            ack_d = 1'b0;
            st_d  = S_WRD;
          end
        end
        S_RD: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              cnt_d = 4'h0;
              st_d  = S_RACK;
            end else begin
              cnt_d = cnt_q + 4'h1;
              tx_d  = {tx_q[6:0], 1'b0};
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            nack_d = sda_s_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = S_IDLE;
            end else begin
              tx_d  = map_rd(sel_q, ptr_q);
              ptr_d = ptr_q + 8'h01;
              st_d  = S_RD;
            end
          end
        end
        S_IDLE: begin
          cnt_d = 4'h0;
        end
        default: begin
          st_d  = S_IDLE;
          ack_d = 1'b0;
        end
      endcase
    end
    oe_d = ack_d | (st_d == S_RD && !tx_d[7]);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= S_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      tx_q   <= 8'h00;
      sel_q  <= 1'b0;
      rw_q   <= 1'b0;
      ack_q  <= 1'b0;
      nack_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      tx_q   <= tx_d;
      sel_q  <= sel_d;
      rw_q   <= rw_d;
      ack_q  <= ack_d;
      nack_q <= nack_d;
      oe_q   <= oe_d;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // Register slave
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [0:0]  ctrl_q, ctrl_d;
  logic [15:0] los_lvl_q, los_lvl_d;
  logic [4:0]  mask_q, mask_d, stat_q, stat_d, ev, w1c;
  logic [8:0]  acc_q, acc_d;
  logic        pend_q, pend_d;
  logic [7:0]  pdata_q, pdata_d;
  logic        do_wr;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [OMMS_TXDIS_CW-1:0] off_cnt_q, off_cnt_d;
  logic        dis, laser_q, laser_d, txf_q, txf_d, los_q, los_d, irq_q, irq_d;

  function automatic logic [31:0] strb_mix(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      strb_mix[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : strb_mix

  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;

  always_comb begin
    aw_got_d  = aw_got_q | (s_axi_awvalid & s_axi_awready);
    w_got_d   = w_got_q | (s_axi_wvalid & s_axi_wready);
    awaddr_d  = aw_got_q ? awaddr_q : s_axi_awaddr;
    wdata_d   = w_got_q ? wdata_q : s_axi_wdata;
    wstrb_d   = w_got_q ? wstrb_q : s_axi_wstrb;
    wa        = awaddr_d;
    wd        = wdata_d;
    ws        = wstrb_d;
    do_wr     = aw_got_d & w_got_d & ~bvalid_q;
    bvalid_d  = bvalid_q & ~s_axi_bready;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    los_lvl_d = los_lvl_q;
    mask_d    = mask_q;
    acc_d     = acc_q;
    pend_d    = pend_q & ser_we;
    pdata_d   = pdata_q;
    w1c       = 5'h00;
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = OMMS_RESP_OKAY;
      case (wa)
        OMMS_REG_CTRL:     ctrl_d = 1'(strb_mix({31'h0, ctrl_q}, wd, ws));
        OMMS_REG_IRQ_STAT: w1c = ws[0] ? wd[4:0] : 5'h00;
        OMMS_REG_IRQ_MASK: mask_d = 5'(strb_mix({27'h0, mask_q}, wd, ws));
        OMMS_REG_LOS_LVL:  los_lvl_d = 16'(strb_mix({16'h0, los_lvl_q},
                                                    wd, ws));
        OMMS_REG_MAP_ACC:  acc_d = 9'(strb_mix({23'h0, acc_q}, wd, ws));
        OMMS_REG_MAP_DATA: begin
          pend_d  = ws[0];
          pdata_d = wd[7:0];
        end
        OMMS_REG_STATUS, OMMS_REG_FLAGS: bresp_d = OMMS_RESP_OKAY;
        default: bresp_d = OMMS_RESP_SLVERR;
      endcase
    end
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = OMMS_RESP_OKAY;
      case (s_axi_araddr)
        OMMS_REG_CTRL:     rdata_d = {31'h0, ctrl_q};
        OMMS_REG_STATUS:   rdata_d = {26'h0, st_q != S_IDLE, txd_s_q, los_q,
                                      txf_q, off_cnt_q == OMMS_TXDIS_CW'(
                                      OMMS_TXDIS_MAX_CYC), laser_q};
        OMMS_REG_IRQ_STAT: rdata_d = {27'h0, stat_q};
        OMMS_REG_IRQ_MASK: rdata_d = {27'h0, mask_q};
        OMMS_REG_LOS_LVL:  rdata_d = {16'h0, los_lvl_q};
        OMMS_REG_MAP_ACC:  rdata_d = {23'h0, acc_q};
        OMMS_REG_MAP_DATA: rdata_d = {24'h0, map_rd(acc_q[8], acc_q[7:0])};
        OMMS_REG_FLAGS:    rdata_d = {12'h0, wlo_q, whi_q, alo_q, ahi_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = OMMS_RESP_SLVERR;
        end
      endcase
    end
    // Transmit side and status outputs
    dis       = txd_s_q | ctrl_q[0];
    laser_d   = ~dis;
    off_cnt_d = !dis ? '0 :
                (off_cnt_q == OMMS_TXDIS_CW'(OMMS_TXDIS_MAX_CYC)) ? off_cnt_q :
                off_cnt_q + OMMS_TXDIS_CW'(1);
    txf_d     = ahi_q[2] | ahi_q[3];
    los_d     = mon_q[4] < los_lvl_q;
    ev        = '0;
    ev[OMMS_IRQ_TXF]   = txf_d & ~txf_q;
    ev[OMMS_IRQ_LOS]   = los_d & ~los_q;
    ev[OMMS_IRQ_ALARM] = |({ahi_d, alo_d} & ~{ahi_q, alo_q});
    ev[OMMS_IRQ_WARN]  = |({whi_d, wlo_d} & ~{whi_q, wlo_q});
    ev[OMMS_IRQ_SWR]   = ser_we;
    stat_d = (stat_q & ~w1c) | ev;
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= OMMS_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= OMMS_RESP_OKAY;
      rdata_q   <= 32'h0;
      ctrl_q    <= OMMS_CTRL_RST;
      los_lvl_q <= OMMS_LOS_LVL_RST;
      mask_q    <= OMMS_IRQ_MASK_RST;
      stat_q    <= 5'h00;
      acc_q     <= 9'h000;
      pend_q    <= 1'b0;
      pdata_q   <= 8'h00;
      off_cnt_q <= '0;
      laser_q   <= 1'b0;
      txf_q     <= 1'b0;
      los_q     <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      los_lvl_q <= los_lvl_d;
      mask_q    <= mask_d;
      stat_q    <= stat_d;
      acc_q     <= acc_d;
      pend_q    <= pend_d;
      pdata_q   <= pdata_d;
      off_cnt_q <= off_cnt_d;
      laser_q   <= laser_d;
      txf_q     <= txf_d;
      los_q     <= los_d;
      irq_q     <= irq_d;
    end
  end

  // Map stores; a software map write waits out a serial write cycle
  always_ff @(posedge mclk) begin
    if (ser_we) begin
      diag_mem[ptr_q] <= sh_q;
    end else if (pend_q && acc_q[8]) begin
      diag_mem[acc_q[7:0]] <= pdata_q;
    end
    if (pend_q && !acc_q[8] && !ser_we) begin
      id_mem[acc_q[7:0]] <= pdata_q;
    end
  end

  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rresp      = rresp_q;
  assign s_axi_rdata      = rdata_q;
  assign laser_enable     = laser_q;
  assign tx_fault         = txf_q;
  assign rx_no_light_flag = los_q;
  assign module_present_n = 1'b0;
  assign irq              = irq_q;

endmodule : omms_top

/* sim/omms_asserts.sv */
// Port checker for the optical module management block.
// Assumes one mclk domain; bound into omms_top below.
`timescale 1ns/1ps
module omms_asserts (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        tx_disable,
  input wire logic        laser_enable,
  input wire logic        module_present_n
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_laser_off;
    tx_disable [*5] |-> !laser_enable;
  endproperty
  a_laser_off: assert property (p_laser_off)
    else $error("laser on while disabled");
  property p_present;
    module_present_n == 1'b0;
  endproperty
  a_present: assert property (p_present)
    else $error("presence line not low");
  property p_open_drain;
    sda_oe |-> sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
  property p_data_on_low;
    $changed(sda_oe) |-> !scl_i;
  endproperty
  a_data_on_low: assert property (p_data_on_low)
    else $error("data changed while clock high");
  property p_drive_len;
    $rose(sda_oe) |-> sda_oe [*4];
  endproperty
  a_drive_len: assert property (p_drive_len)
    else $error("driven bit too short");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("no read response");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");

  c_b_wait: cover property (s_axi_bvalid && !s_axi_bready);
  c_r_wait: cover property (s_axi_rvalid && !s_axi_rready);
  c_ack: cover property ($rose(sda_oe));
  c_off: cover property ($fell(laser_enable));
endmodule : omms_asserts

bind omms_top omms_asserts chk_u (.mclk(mclk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .tx_disable(tx_disable),
  .laser_enable(laser_enable), .module_present_n(module_present_n));

/* sim/omms_host_model.sv */
// Host serial master: makes the serial clock, pulls data low open-drain.
// Assumes a pull-up on the data line; clock stands high between frames.
`timescale 1ns/1ps
module omms_host_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Offset of 13 ns keeps every edge clear of mclk edges
  task automatic start;
    #13;
    sda_pull = 1'b0;
    #225;
    scl = 1'b1;
    #75;
    sda_pull = 1'b1;
    #75;
    scl = 1'b0;
  endtask : start
  task automatic stop;
    #125;
    sda_pull = 1'b1;
    #125;
    scl = 1'b1;
    #75;
    sda_pull = 1'b0;
    #75;
  endtask : stop
  // Low 250 ns, high 150 ns: a 400 ns bit
  task automatic bit_x(input logic b, output logic r);
    #125;
    sda_pull = !b;
    #125;
    scl = 1'b1;
    #75;
    r = sda_line;
    #75;
    scl = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ack_in, ack);
  endtask : xfer
endmodule : omms_host_model

/* sim/tb_top.sv */
// Bench for the management block: AXI4-Lite master and serial host.
// Assumes omms_pkg, the checker and the host model are compiled first.
`timescale 1ns/1ps
module tb_top
  import omms_pkg::*;
;
  logic        mclk, arst_n, tx_disable, scl, host_pull, sda_line, k;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, sda_o, sda_oe, laser_enable;
  logic        tx_fault, no_light, present_n, irq;
  logic [7:0]  awaddr, araddr, q0, q1;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, rsp;
  omms_mon_t   mon;
  int          n_fail, tests_run;

  assign sda_line = !(host_pull || (sda_oe && !sda_o));
  omms_host_model host_u (.scl(scl), .sda_pull(host_pull),
                          .sda_line(sda_line));
  omms_top dut_u (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .tx_disable(tx_disable), .mon_in(mon), .laser_enable(laser_enable),
    .tx_fault(tx_fault), .rx_no_light_flag(no_light),
    .module_present_n(present_n), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic conclude;
    $display("fails %0d checks %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n >= 300) begin
      n_fail++;
      conclude();
    end
  endtask : guard
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n = 0;
    logic aw = 1'b1;
    logic w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((aw || w) && n < 300) begin
      @(posedge mclk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
      n++;
    end
    // Late ready exercises the held response
    @(posedge mclk);
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!bvalid && n < 300);
    rsp = bresp;
    bready <= 1'b0;
    guard(n);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!arready && n < 300);
    arvalid <= 1'b0;
    @(posedge mclk);
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!rvalid && n < 300);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    guard(n);
  endtask : axi_rd
  // Preset content: id bytes scrambled, diag limits wide open
  function automatic logic [7:0] fill(input logic s, input logic [7:0] i);
    if (!s) return i ^ 8'h5a;
    if (i < 8'h28) return i[1] ? 8'h00 : 8'hff;
    return i;
  endfunction : fill
  task automatic map_wr(input logic s, input logic [7:0] a, d);
    axi_wr(OMMS_REG_MAP_ACC, {23'h0, s, a});
    axi_wr(OMMS_REG_MAP_DATA, {24'h0, d});
  endtask : map_wr
  task automatic map_rd(input logic s, input logic [7:0] a);
    axi_wr(OMMS_REG_MAP_ACC, {23'h0, s, a});
    axi_rd(OMMS_REG_MAP_DATA);
  endtask : map_rd
  task automatic ser_wr(input logic [6:0] dev, input logic [7:0] wa, d0, d1);
    logic [7:0] b[4];
    b = '{{dev, 1'b0}, wa, d0, d1};
    host_u.start();
    foreach (b[i]) begin
      host_u.xfer(b[i], 1'b1, q0, k);
      chk("ack_wr", 0, 32'(k));
    end
    host_u.stop();
    @(posedge mclk);
  endtask : ser_wr
  task automatic ser_rd(input logic [6:0] dev, input logic [7:0] wa);
    host_u.start();
    host_u.xfer({dev, 1'b0}, 1'b1, q0, k);
    chk("ack_dev", 0, 32'(k));
    host_u.xfer(wa, 1'b1, q0, k);
    host_u.start();
    host_u.xfer({dev, 1'b1}, 1'b1, q0, k);
    host_u.xfer(8'hff, 1'b0, q0, k);
    host_u.xfer(8'hff, 1'b1, q1, k);
    host_u.stop();
    @(posedge mclk);
  endtask : ser_rd

  task automatic t_regs;
    axi_rd(OMMS_REG_IRQ_MASK);
    chk("mask_rst", 0, v);
    axi_rd(OMMS_REG_LOS_LVL);
    chk("los_rst", 0, v);
    axi_rd(8'h20);
    chk("bad_rd", 32'(OMMS_RESP_SLVERR), 32'(rsp));
    axi_wr(8'h24, 32'h1);
    chk("bad_wr", 32'(OMMS_RESP_SLVERR), 32'(rsp));
    chk("present", 0, 32'(present_n));
    $display("done t_regs");
  endtask : t_regs
  task automatic t_laser;
    int n = 0;
    tx_disable <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("laser_on", 1, 32'(laser_enable));
    axi_wr(OMMS_REG_CTRL, 32'h1);
    chk("sw_off", 0, 32'(laser_enable));
    axi_wr(OMMS_REG_CTRL, 32'h0);
    tx_disable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (laser_enable !== 1'b0 && n < 300);
    chk("off_time", 1, 32'(n <= 200));
    repeat (200) @(posedge mclk);
    axi_rd(OMMS_REG_STATUS);
    chk("status", 32'h12, v & 32'h13);
    $display("done t_laser");
  endtask : t_laser
  task automatic t_id;
    ser_rd(OMMS_DEV_ID, 8'hff);
    chk("id_ff", 32'(fill(0, 8'hff)), 32'(q0));
    chk("id_wrap", 32'(fill(0, 8'h00)), 32'(q1));
    ser_wr(OMMS_DEV_ID, 8'h05, 8'h00, 8'h00);
    map_rd(0, 8'h05);
    chk("id_kept", 32'(fill(0, 8'h05)), v);
    // Address 0x52 belongs to nobody
    host_u.start();
    host_u.xfer(8'ha4, 1'b1, q0, k);
    chk("nack", 1, 32'(k));
    host_u.stop();
    @(posedge mclk);
    $display("done t_id");
  endtask : t_id
  task automatic t_diag;
    axi_wr(OMMS_REG_IRQ_MASK, 32'h10);
    ser_wr(OMMS_DEV_DIAG, 8'h7f, 8'h3c, 8'hc3);
    chk("irq_set", 1, 32'(irq));
    map_rd(1, 8'h7f);
    chk("wp_kept", 32'h7f, v);
    map_rd(1, 8'h80);
    chk("stored", 32'hc3, v);
    axi_wr(OMMS_REG_IRQ_STAT, 32'h10);
    chk("irq_clr", 0, 32'(irq));
    axi_wr(OMMS_REG_IRQ_MASK, 32'h0);
    ser_wr(OMMS_DEV_DIAG, 8'h90, 8'h11, 8'h22);
    chk("irq_mask", 0, 32'(irq));
    axi_rd(OMMS_REG_IRQ_STAT);
    chk("stat", 32'h10, v & 32'h10);
    axi_wr(OMMS_REG_IRQ_STAT, 32'h1f);
    $display("done t_diag");
  endtask : t_diag
  task automatic t_mon;
    mon.temp <= 16'h5678;
    ser_rd(OMMS_DEV_DIAG, 8'h60);
    chk("temp_hi", 32'h56, 32'(q0));
    chk("temp_lo", 32'h78, 32'(q1));
    map_wr(1, 8'h10, 8'h10);
    chk("fault_off", 0, 32'(tx_fault));
    mon.bias <= 16'h2000;
    repeat (4) @(posedge mclk);
    chk("fault", 1, 32'(tx_fault));
    axi_rd(OMMS_REG_FLAGS);
    chk("flags", 32'h4, v);
    mon.bias <= 16'h0800;
    axi_wr(OMMS_REG_LOS_LVL, 32'h0500);
    repeat (4) @(posedge mclk);
    chk("fault_clr", 0, 32'(tx_fault));
    chk("no_light", 1, 32'(no_light));
    mon.rxpwr <= 16'h0600;
    repeat (4) @(posedge mclk);
    chk("light", 0, 32'(no_light));
    $display("done t_mon");
  endtask : t_mon

  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    tx_disable = 1'b1;
    mon = '{16'h1234, 16'h3300, 16'h0800, 16'h0600, 16'h0400};
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 512; i++) begin
      map_wr(i[8], i[7:0], fill(i[8], i[7:0]));
    end
    t_regs();
    t_laser();
    t_id();
    t_diag();
    t_mon();
    conclude();
  end
endmodule : tb_top
